// ==== hdl/qpc_front_end.sv ====
// Functional notes
// - First byte of frame is address byte.
// - Upper address nibble checked against type identifier.
// - Address bits 1..0 must match straps.
// - Mismatched device never executes the instruction.
// - Second byte is instruction; top nibble opcode.
// - Instruction bits 3..2 select stored register.
// - Instruction bits 1..0 select wiper register.
// - Wiper settles 5 to 10 us after instruction.
// - Wiper settles 5 to 10 us after power-up.
// - Nonvolatile update finishes within 5 ms.
// - Power-up loads wipers from stored register zero.
`timescale 1ns/10ps

module qpc_front_end
    import qpc_pkg::*;
#(
    parameter logic [3:0] TYPE_ID        = 4'hA, // Arbitrary value
    parameter int         NV_WRITE_COUNT = NV_WRITE_CYCLES
) (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       spiClk,
    input  wire logic       chipSelN,
    input  wire logic       serialIn,
    input  wire logic       strap_addr_bit0,
    input  wire logic       strap_addr_bit1,
    input  wire logic       wiperChangeReq,
    input  wire logic       nvWriteStart,
    output logic            serialOut,
    output logic            serialOutEn,
    output logic            cmdValid,
    output logic            addrMismatch,
    output logic            frameIgnored,
    output logic [3:0]      opcode_field,
    output logic            stored_sel_hi,
    output logic            stored_sel_lo,
    output logic [1:0]      wiper_sel_field,
    output logic            wiperLoadZero,
    output logic            wiperSettled,
    output logic            wiperSettling,
    output logic            nvBusy,
    output logic            nvDone
);

    localparam int NVW = $clog2(NV_WRITE_COUNT + 1);

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    logic [4:0] syncA;
    logic [4:0] syncB;
    logic       sclkPrev;
    logic       sclkRise;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            syncA    <= 5'h1F;
            syncB    <= 5'h1F;
            sclkPrev <= 1'b1;
        end else begin
            syncA    <= {strap_addr_bit1, strap_addr_bit0, serialIn, chipSelN, spiClk};
            syncB    <= syncA;
            sclkPrev <= syncB[0];
        end
    end

    assign sclkRise = syncB[0] & ~sclkPrev;

    // ==========================================================
    // Frame decoder
    // ==========================================================
    qpc_state_type state;
    qpc_state_type next_state;
    logic [7:0]    shiftReg;
    logic [7:0]    next_shiftReg;
    logic [2:0]    bitCnt;
    logic [2:0]    next_bitCnt;
    logic [7:0]    inByte;
    logic          next_cmdValid;
    logic          next_addrMismatch;
    logic [3:0]    next_opcode;
    logic          next_selHi;
    logic          next_selLo;
    logic [1:0]    next_wiperSel;

    always_comb begin
        next_state        = state;
        next_shiftReg     = shiftReg;
        next_bitCnt       = bitCnt;
        next_cmdValid     = 1'b0;
        next_addrMismatch = 1'b0;
        next_opcode       = opcode_field;
        next_selHi        = stored_sel_hi;
        next_selLo        = stored_sel_lo;
        next_wiperSel     = wiper_sel_field;
        inByte            = {shiftReg[6:0], syncB[2]};
        if (syncB[1]) begin
            // Deselect ends any frame, matched or not
            next_state  = QPC_IDLE;
            next_bitCnt = 3'h0;
        end else begin
            case (state)
                QPC_IDLE: begin
                    next_state  = QPC_ADDR;
                    next_bitCnt = 3'h0;
                end
                QPC_ADDR, QPC_INSTR: begin
                    if (sclkRise) begin
                        next_shiftReg = inByte;
                        next_bitCnt   = bitCnt + 3'h1;
                        if (bitCnt == LAST_BIT && state == QPC_ADDR) begin
                            // Bits 3..2 are not checked: the host keeps them zero
                            if (inByte[TYPE_MSB:TYPE_LSB] == TYPE_ID
                                && inByte[1] == syncB[4] && inByte[0] == syncB[3]) begin
                                next_state = QPC_INSTR;
                            end else begin
                                next_state        = QPC_IGNORE;
                                next_addrMismatch = 1'b1;
                            end
                        end else if (bitCnt == LAST_BIT) begin
                            next_state    = QPC_DONE;
                            next_cmdValid = 1'b1;
                            next_opcode   = inByte[OPCODE_MSB:OPCODE_LSB];
                            next_selHi    = inByte[STORED_SEL_HI];
                            next_selLo    = inByte[STORED_SEL_LO];
                            next_wiperSel = inByte[WIPER_SEL_MSB:WIPER_SEL_LSB];
                        end
                    end
                end
                default: begin
                    next_state = state;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state           <= QPC_IDLE;
            shiftReg        <= 8'h00;
            bitCnt          <= 3'h0;
            cmdValid        <= 1'b0;
            addrMismatch    <= 1'b0;
            frameIgnored    <= 1'b0;
            opcode_field    <= 4'h0;
            stored_sel_hi   <= 1'b0;
            stored_sel_lo   <= 1'b0;
            wiper_sel_field <= 2'h0;
            serialOut       <= 1'b0;
            serialOutEn     <= 1'b0;
        end else begin
            state           <= next_state;
            shiftReg        <= next_shiftReg;
            bitCnt          <= next_bitCnt;
            cmdValid        <= next_cmdValid;
            addrMismatch    <= next_addrMismatch;
            frameIgnored    <= (next_state == QPC_IGNORE);
            opcode_field    <= next_opcode;
            stored_sel_hi   <= next_selHi;
            stored_sel_lo   <= next_selLo;
            wiper_sel_field <= next_wiperSel;
            // No data phase here, so the output stays released
            serialOut       <= 1'b0;
            serialOutEn     <= 1'b0;
        end
    end

    // ==========================================================
    // Power-up load and wiper settle timer
    // ==========================================================
    logic                    powerUpDone;
    logic                    next_loadZero;
    logic                    settleBusy;
    logic                    next_settleBusy;
    logic [SETTLE_CNT_W-1:0] settleCnt;
    logic [SETTLE_CNT_W-1:0] next_settleCnt;
    logic                    next_settled;

    always_comb begin
        next_loadZero   = ~powerUpDone;
        next_settleBusy = settleBusy;
        next_settleCnt  = settleCnt;
        next_settled    = 1'b0;
        if (wiperChangeReq || !powerUpDone) begin
            // A new request restarts the full settle time
            next_settleBusy = 1'b1;
            next_settleCnt  = '0;
        end else if (settleBusy) begin
            if (settleCnt == SETTLE_CNT_W'(WIPER_SETTLE_CYCLES - 1)) begin
                next_settleBusy = 1'b0;
                next_settled    = 1'b1;
            end else begin
                next_settleCnt = settleCnt + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            powerUpDone   <= 1'b0;
            wiperLoadZero <= 1'b0;
            settleBusy    <= 1'b0;
            settleCnt     <= '0;
            wiperSettled  <= 1'b0;
            wiperSettling <= 1'b0;
        end else begin
            powerUpDone   <= 1'b1;
            wiperLoadZero <= next_loadZero;
            settleBusy    <= next_settleBusy;
            settleCnt     <= next_settleCnt;
            wiperSettled  <= next_settled;
            wiperSettling <= next_settleBusy;
        end
    end

    // ==========================================================
    // Nonvolatile write timer
    // ==========================================================
    logic [NVW-1:0] nvCnt;
    logic [NVW-1:0] next_nvCnt;
    logic           next_nvBusy;
    logic           next_nvDone;

    always_comb begin
        next_nvCnt  = nvCnt;
        next_nvBusy = nvBusy;
        next_nvDone = 1'b0;
        if (nvBusy) begin
            // Starts during a write are dropped; one write at a time
            if (nvCnt == NVW'(NV_WRITE_COUNT - 1)) begin
                next_nvBusy = 1'b0;
                next_nvDone = 1'b1;
                next_nvCnt  = '0;
            end else begin
                next_nvCnt = nvCnt + 1'b1;
            end
        end else if (nvWriteStart) begin
            next_nvBusy = 1'b1;
            next_nvCnt  = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            nvCnt  <= '0;
            nvBusy <= 1'b0;
            nvDone <= 1'b0;
        end else begin
            nvCnt  <= next_nvCnt;
            nvBusy <= next_nvBusy;
            nvDone <= next_nvDone;
        end
    end

endmodule

// ==== hdl/qpc_pkg.sv ====
package qpc_pkg;

    // ==========================================================
    // Clock and timing
    // ==========================================================
    localparam int CLK_FREQ_MHZ        = 200;
    localparam int WIPER_SETTLE_MIN_US = 5;
    localparam int WIPER_SETTLE_MAX_US = 10;
    localparam int NV_WRITE_MAX_MS     = 5;
    // Least time rounds up; exact at this rate
    localparam int WIPER_SETTLE_CYCLES = WIPER_SETTLE_MIN_US * CLK_FREQ_MHZ;
    localparam int WIPER_SETTLE_LIMIT  = WIPER_SETTLE_MAX_US * CLK_FREQ_MHZ;
    localparam int NV_WRITE_CYCLES     = NV_WRITE_MAX_MS * 1000 * CLK_FREQ_MHZ;
    localparam int SETTLE_CNT_W        = 11;

    // ==========================================================
    // Frame layout
    // ==========================================================
    localparam int TYPE_MSB       = 7;
    localparam int TYPE_LSB       = 4;
    localparam int OPCODE_MSB     = 7;
    localparam int OPCODE_LSB     = 4;
    localparam int STORED_SEL_HI  = 3;
    localparam int STORED_SEL_LO  = 2;
    localparam int WIPER_SEL_MSB  = 1;
    localparam int WIPER_SEL_LSB  = 0;
    localparam logic [2:0] LAST_BIT = 3'h7;

    typedef enum logic [2:0] {
        QPC_IDLE   = 3'b000,
        QPC_ADDR   = 3'b001,
        QPC_INSTR  = 3'b010,
        QPC_DONE   = 3'b011,
        QPC_IGNORE = 3'b100
    } qpc_state_type;

endpackage

// ==== testbench/qpc_front_end_properties.sv ====
`timescale 1ns/10ps
// ==========================================================
// Front end checker
module qpc_front_end_properties #(
    parameter int NV_WRITE_COUNT = 20
) (
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic       chipSelN,
    input wire logic       wiperChangeReq,
    input wire logic       nvWriteStart,
    input wire logic       serialOutEn,
    input wire logic       cmdValid,
    input wire logic       addrMismatch,
    input wire logic       frameIgnored,
    input wire logic [3:0] opcode_field,
    input wire logic       wiperLoadZero,
    input wire logic       wiperSettled,
    input wire logic       wiperSettling,
    input wire logic       nvBusy,
    input wire logic       nvDone
);
    logic        rstSeen;
    logic [11:0] settleCnt;
    logic [31:0] nvCnt;
    // Reset release counts as a settle request
    always_ff @(posedge sys_clk) begin
        rstSeen   <= rst_n;
        settleCnt <= !rst_n ? 12'h000 : (wiperChangeReq || !rstSeen) ? 12'h001 :
                     wiperSettling ? settleCnt + 12'h001 : 12'h000;
        nvCnt     <= (rst_n && nvBusy) ? nvCnt + 32'h1 : 32'h0;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_output_released: assert property (!serialOutEn) else $error("serial output driven");
    a_settle_exact: assert property (wiperSettled |-> settleCnt == 12'h3E9) else $error("settle length");
    a_settle_bound: assert property (settleCnt <= 12'h7D0) else $error("settle too long");
    a_load_once: assert property (wiperLoadZero |-> settleCnt == 12'h001 ##1 !wiperLoadZero)
        else $error("wiper load not at power-up");
    a_nv_length: assert property (nvDone |-> !nvBusy && nvCnt == NV_WRITE_COUNT) else $error("nv length");
    a_nv_start: assert property (nvWriteStart && !nvBusy |=> nvBusy) else $error("nv not started");
    a_mismatch_ignores: assert property (addrMismatch |-> (frameIgnored && !cmdValid)[*3])
        else $error("rejected frame not ignored");
    a_no_cmd_ignored: assert property (frameIgnored |-> !cmdValid) else $error("command in ignored frame");
    a_cmd_pulse: assert property (cmdValid |=> !cmdValid) else $error("command pulse too long");
    a_fields_hold: assert property (!cmdValid |-> $stable(opcode_field)) else $error("opcode moved");
    a_cmd_in_frame: assert property (cmdValid |-> !$past(chipSelN, 4)) else $error("command outside frame");
endmodule

// ==== testbench/qpc_host_model.sv ====
`timescale 1ns/10ps
// ==========================================================
// Serial host master
module qpc_host_model (
    output logic spiClk,
    output logic chipSelN,
    output logic serialIn
);
    initial begin
        spiClk   = 1'b0;
        chipSelN = 1'b1;
        serialIn = 1'b0;
    end
    // Clock stands low outside frames
    task automatic frame(input logic [15:0] bits, input int n);
        // Quarter-ns offset keeps pin edges off the sampling clock edges
        #0.25 chipSelN = 1'b0;
        #64;
        for (int k = 15; k > 15 - n; k--) begin
            serialIn = bits[k];
            #32 spiClk = 1'b1;
            #32 spiClk = 1'b0;
        end
        #32 chipSelN = 1'b1;
        // Released line must not look like held data
        serialIn = ~serialIn;
        #320;
    endtask
endmodule

// ==== testbench/qpc_front_end_test.sv ====
`timescale 1ns/10ps
// ==========================================================
// Bench
module qpc_front_end_test;
    import qpc_pkg::*;
    localparam logic [3:0] TYPE_ID  = 4'h6; // Arbitrary value
    localparam int         NV_COUNT = 20;
    logic sys_clk = 1'b0, rst_n = 1'b0, strap_addr_bit0 = 1'b1, strap_addr_bit1 = 1'b0;
    logic wiperChangeReq = 1'b0, nvWriteStart = 1'b0, spiClk, chipSelN, serialIn, serialOut, serialOutEn;
    logic cmdValid, addrMismatch, frameIgnored, stored_sel_hi, stored_sel_lo, wiperLoadZero;
    logic wiperSettled, wiperSettling, nvBusy, nvDone;
    logic [3:0] opcode_field;
    logic [1:0] wiper_sel_field;
    int fails = 0, checks_done = 0, cycles = 0, cmdSeen = 0, missSeen = 0;
    always #2.5 sys_clk = ~sys_clk;
    qpc_host_model i_host (.spiClk, .chipSelN, .serialIn);
    qpc_front_end #(.TYPE_ID(TYPE_ID), .NV_WRITE_COUNT(NV_COUNT)) i_dut (.sys_clk, .rst_n, .spiClk, .chipSelN,
        .serialIn, .strap_addr_bit0, .strap_addr_bit1, .wiperChangeReq, .nvWriteStart, .serialOut, .serialOutEn,
        .cmdValid, .addrMismatch, .frameIgnored, .opcode_field, .stored_sel_hi, .stored_sel_lo, .wiper_sel_field,
        .wiperLoadZero, .wiperSettled, .wiperSettling, .nvBusy, .nvDone);
    always @(posedge sys_clk) begin
        cycles++;
        if (cmdValid === 1'b1) cmdSeen++;
        if (addrMismatch === 1'b1) missSeen++;
        if (cycles == 20000) begin
            fails++;
            end_of_test();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Waits for a pulse, counting edges from the call
    task automatic count_to(input logic pickNv, output int n);
        n = 0;
        while ((pickNv ? nvDone : wiperSettled) !== 1'b1 && n < 3000) begin
            @(posedge sys_clk);
            #1 n++;
        end
    endtask
    task automatic t_powerup;
        int n;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        #1 chk({15'h0, wiperLoadZero}, 16'h0001);
        count_to(1'b0, n);
        chk(n[15:0], 16'(WIPER_SETTLE_CYCLES));
    endtask
    task automatic t_frame(input logic [7:0] addr, input logic [7:0] instr, input logic hit);
        int c, m;
        c = cmdSeen;
        m = missSeen;
        @(posedge sys_clk);
        i_host.frame({addr, instr}, 16);
        chk(16'(cmdSeen - c), {15'h0, hit});
        chk(16'(missSeen - m), {15'h0, !hit});
        if (hit) chk({8'h00, opcode_field, stored_sel_hi, stored_sel_lo, wiper_sel_field}, {8'h00, instr});
    endtask
    task automatic t_decode;
        for (int k = 0; k < 4; k++) begin
            @(posedge sys_clk);
            {strap_addr_bit1, strap_addr_bit0} <= 2'(k);
            repeat (4) @(posedge sys_clk);
            // Address bits 3..2 sent as zero
            t_frame({TYPE_ID, 2'b00, 2'(k)}, {4'(4'h9 + k), 2'(k), 2'(3 - k)}, 1'b1);
        end
    endtask
    task automatic t_reject;
        t_frame({~TYPE_ID, 4'h3}, 8'hA1, 1'b0);
        t_frame({TYPE_ID, 4'h2}, 8'hA1, 1'b0);
        t_frame({TYPE_ID, 4'h1}, 8'hC6, 1'b0);
        chk({8'h00, opcode_field, stored_sel_hi, stored_sel_lo, wiper_sel_field}, 16'h00CC);
        t_frame({TYPE_ID, 4'h3}, 8'h5E, 1'b1);
    endtask
    task automatic t_settle;
        int n;
        @(posedge sys_clk) wiperChangeReq <= 1'b1;
        @(posedge sys_clk) wiperChangeReq <= 1'b0;
        repeat (500) @(posedge sys_clk);
        // Restart mid-count
        wiperChangeReq <= 1'b1;
        @(posedge sys_clk) wiperChangeReq <= 1'b0;
        count_to(1'b0, n);
        chk(n[15:0], 16'(WIPER_SETTLE_CYCLES));
    endtask
    task automatic t_nv;
        int n;
        @(posedge sys_clk) nvWriteStart <= 1'b1;
        @(posedge sys_clk) nvWriteStart <= 1'b0;
        repeat (4) @(posedge sys_clk);
        // Start while busy must be dropped
        nvWriteStart <= 1'b1;
        @(posedge sys_clk) nvWriteStart <= 1'b0;
        count_to(1'b1, n);
        chk(n[15:0], 16'(NV_COUNT - 5));
        repeat (3) @(posedge sys_clk);
        #1 chk({15'h0, nvBusy}, 16'h0000);
    endtask
    initial begin
        t_powerup();
        t_decode();
        t_reject();
        t_settle();
        t_nv();
        end_of_test();
    end
endmodule
bind qpc_front_end qpc_front_end_properties #(.NV_WRITE_COUNT(NV_WRITE_COUNT)) i_props (.sys_clk, .rst_n,
    .chipSelN, .wiperChangeReq, .nvWriteStart, .serialOutEn, .cmdValid, .addrMismatch, .frameIgnored,
    .opcode_field, .wiperLoadZero, .wiperSettled, .wiperSettling, .nvBusy, .nvDone);
